// File: hdl/acp_pkg.sv
// Package of constants and types for the converter mode configuration port
package acp_pkg;
  // Register offsets
  localparam logic [6:0] SOFT_RESET_CTRL_ADDR = 7'h00;
  localparam logic [6:0] POWER_DOWN_CTRL_ADDR = 7'h01;
  localparam logic [6:0] OUTPUT_CLOCK_TIMING_ADDR = 7'h02;
  localparam logic [6:0] OUTPUT_DRIVER_MODE_ADDR = 7'h03;
  localparam logic [6:0] DATA_FORMAT_CTRL_ADDR = 7'h04;
  localparam int NUM_REGS = 5;
  // Reset values
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  // Field positions
  localparam int SOFT_RESET_BIT = 7;
  localparam int OUTCLK_INVERT_BIT = 3;
  localparam int OUTCLK_PHASE_LSB = 1;
  localparam int DCS_BIT = 0;
  localparam int LVDS_CURRENT_LSB = 4;
  localparam int TERMINATION_BIT = 3;
  localparam int TRISTATE_BIT = 2;
  localparam int FORMAT_LSB = 0;
  localparam int TEST_PATTERN_LSB = 3;
  localparam int ALT_POLARITY_BIT = 2;
  localparam int RANDOMIZER_BIT = 1;
  localparam int TWOS_COMP_BIT = 0;
  // Writable bit masks; unused bits never store
  localparam logic [7:0] POWER_DOWN_MASK = 8'h03;
  localparam logic [7:0] TIMING_MASK = 8'h0F;
  localparam logic [7:0] DRIVER_MODE_MASK = 8'h7F;
  localparam logic [7:0] DATA_FORMAT_MASK = 8'h3F;
  // Serial word layout
  localparam int WORD_BITS = 16;
  localparam int DATA_BITS = 8;
  localparam logic [4:0] WORD_BITS_COUNT = 5'h10;
  localparam logic [4:0] DATA_PHASE_START = 5'h08;
  // Encodings
  localparam logic [1:0] FORMAT_FULL_CMOS = 2'h0;
  localparam logic [1:0] FORMAT_DDR_LVDS = 2'h1;
  localparam logic [1:0] FORMAT_DDR_CMOS = 2'h2;
  localparam logic [1:0] FORMAT_UNUSED = 2'h3;
  localparam logic [2:0] LVDS_CURRENT_3P5MA = 3'h0;
  localparam logic [2:0] LVDS_CURRENT_UNUSED = 3'h3;
  localparam logic [1:0] POWER_SLEEP = 2'h3;
  // Length of the forced sleep pulse after a software reset
  localparam logic [3:0] RESET_SLEEP_CYCLES = 4'h8;
  typedef enum logic [1:0] {
    PD_NORMAL,
    PD_NAP_CH2,
    PD_NAP_BOTH,
    PD_SLEEP
  } acp_power_type;
endpackage

// File: hdl/acp_reg_if.sv
// Interface carrying register writes and reads between serial engine and register bank
`timescale 1ns/100ps
interface acp_reg_if;
  logic wr_en;
  logic [6:0] addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic soft_reset;
  modport engine (output wr_en, output addr, output wr_data, input rd_data, input soft_reset);
  modport bank (input wr_en, input addr, input wr_data, output rd_data, output soft_reset);
endinterface

// File: hdl/acp_reg_bank.sv
// Mode control register bank with software reset
`timescale 1ns/100ps
module acp_reg_bank (
  input wire logic sys_clk,
  input wire logic reset,
  acp_reg_if.bank rif,
  output logic [7:0] power_down_reg,
  output logic [7:0] timing_reg,
  output logic [7:0] driver_mode_reg,
  output logic [7:0] data_format_reg
);

  logic soft_reset_hit;

  assign soft_reset_hit = rif.wr_en && (rif.addr == acp_pkg::SOFT_RESET_CTRL_ADDR)
    && rif.wr_data[acp_pkg::SOFT_RESET_BIT];
  assign rif.soft_reset = soft_reset_hit;

  // --------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------
  // masked writes, reset clears all
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      power_down_reg <= acp_pkg::REG_RESET_VALUE;
      timing_reg <= acp_pkg::REG_RESET_VALUE;
      driver_mode_reg <= acp_pkg::REG_RESET_VALUE;
      data_format_reg <= acp_pkg::REG_RESET_VALUE;
    end else if (soft_reset_hit) begin
      power_down_reg <= acp_pkg::REG_RESET_VALUE;
      timing_reg <= acp_pkg::REG_RESET_VALUE;
      driver_mode_reg <= acp_pkg::REG_RESET_VALUE;
      data_format_reg <= acp_pkg::REG_RESET_VALUE;
    end else if (rif.wr_en) begin
      unique case (rif.addr)
        acp_pkg::POWER_DOWN_CTRL_ADDR: power_down_reg <= rif.wr_data & acp_pkg::POWER_DOWN_MASK;
        acp_pkg::OUTPUT_CLOCK_TIMING_ADDR: timing_reg <= rif.wr_data & acp_pkg::TIMING_MASK;
        acp_pkg::OUTPUT_DRIVER_MODE_ADDR: driver_mode_reg <= rif.wr_data & acp_pkg::DRIVER_MODE_MASK;
        acp_pkg::DATA_FORMAT_CTRL_ADDR: data_format_reg <= rif.wr_data & acp_pkg::DATA_FORMAT_MASK;
        default: ;
      endcase
    end
  end

  // readback mux, reset register reads zero
  always_comb begin
    unique case (rif.addr)
      acp_pkg::POWER_DOWN_CTRL_ADDR: rif.rd_data = power_down_reg;
      acp_pkg::OUTPUT_CLOCK_TIMING_ADDR: rif.rd_data = timing_reg;
      acp_pkg::OUTPUT_DRIVER_MODE_ADDR: rif.rd_data = driver_mode_reg;
      acp_pkg::DATA_FORMAT_CTRL_ADDR: rif.rd_data = data_format_reg;
      default: rif.rd_data = 8'h00;
    endcase
  end

  // reset clears the timing, driver mode and power-down registers next cycle
  chk_soft_reset_clears: assert property (@(posedge sys_clk) disable iff (reset)
    soft_reset_hit |=> (timing_reg == 8'h00) && (driver_mode_reg == 8'h00) && (power_down_reg == 8'h00))
    else $error("Software reset did not clear registers");
  chk_unused_bits_zero: assert property (@(posedge sys_clk) disable iff (reset)
    (timing_reg[7:4] == 4'h0) && (driver_mode_reg[7] == 1'b0) && (power_down_reg[7:2] == 6'h00))
    else $error("Unused register bit became set");
endmodule

// File: hdl/acp_config_port.sv
// Mode configuration port: strap-selected static pins or serial register interface
//
// Summary of operation
// - Strap high: chip-select, clock, serial-in, serial-out are static mode inputs.
// - Static mode: chip-select level sets duty cycle stabilizer off or on.
// - Static mode: clock pin low full rate CMOS, high DDR LVDS 3.5mA.
// - Power-down code from serial-in/out pins or register bits 1-0.
// - Strap low: four pins form serial interface programming mode registers.
// - Chip-select low frames transfer; only first 16 rising clock edges sampled.
// - Word is read/write flag, seven address bits, eight data bits, MSB first.
// - Flag low: data bits written to addressed register.
// - Flag high: register driven on serial-out, unchanged, serial-in ignored.
// - Serial-out is open-drain pull-down only; host supplies pull-up.
// - Bit 7 of register 00h clears all registers and briefly forces sleep.
// - Reset register is write-only; its readback is not meaningful.
// - Timing bit 3 inverts the output clock polarity.
// - Timing bits 2-1 delay output clock by 0, 45, 90 or 135 degrees.
// - Timing bit 0 switches the duty cycle stabilizer.
// - Output mode bits 6-4 select LVDS drive current; code 011 unused.
// - Output mode bit 3 enables termination and doubles drive current.
// - Output mode bit 2 puts every digital output in high impedance.
// - Output mode bits 1-0 select output format; code 11 unused.
// - Inversion plus phase delay gives clock shifts from 0 to 315 degrees.
// - Register 04h holds test pattern, bit polarity, randomizer, two's complement.
`timescale 1ns/100ps
module acp_config_port (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic interface_select,
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic sdi_pin,
  input wire logic sdo_pin_in,
  output logic sdo_pin_out,
  output logic sdo_pin_oe_n,
  output logic duty_cycle_stabilizer,
  output logic [1:0] power_down_code,
  output logic [1:0] output_format_mode,
  output logic [2:0] lvds_drive_current,
  output logic internal_termination,
  output logic output_tristate,
  output logic outclk_invert,
  output logic [1:0] outclk_phase_delay,
  output logic [2:0] outclk_shift_eighths,
  output logic [2:0] test_pattern_select,
  output logic alt_bit_polarity,
  output logic output_randomizer,
  output logic twos_complement
);

  // --------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic strap_s;
  logic cs_n_s;
  logic sck_s;
  logic sdi_s;
  logic sdo_s;

  // Two flops on every pin
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync1_reg <= 5'h1F;
      sync2_reg <= 5'h1F;
    end else begin
      sync1_reg <= {interface_select, cs_n_pin, sck_pin, sdi_pin, sdo_pin_in};
      sync2_reg <= sync1_reg;
    end
  end
  assign {strap_s, cs_n_s, sck_s, sdi_s, sdo_s} = sync2_reg;

  // --------------------------------------------------------------
  // Serial engine
  // --------------------------------------------------------------
  logic sck_prev_reg;
  logic cs_prev_reg;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic serial_mode;
  logic [4:0] bit_count_reg;
  logic [15:0] shift_reg;
  logic read_cmd_reg;
  logic [7:0] read_data_reg;
  logic sdo_low_reg;
  logic wr_pending_reg;
  logic [3:0] sleep_count_reg;
  logic [7:0] power_down_reg;
  logic [7:0] timing_reg;
  logic [7:0] driver_mode_reg;
  logic [7:0] data_format_reg;

  acp_reg_if rif ();

  // serial mode only with strap low
  assign serial_mode = !strap_s;
  assign sck_rise = sck_s && !sck_prev_reg;
  assign sck_fall = !sck_s && sck_prev_reg;
  assign cs_fall = !cs_n_s && cs_prev_reg;
  assign cs_rise = cs_n_s && !cs_prev_reg;

  // Edge history
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sck_prev_reg <= 1'b1; // Matches synchroniser reset, no false edge
      cs_prev_reg <= 1'b1;
    end else begin
      sck_prev_reg <= sck_s;
      cs_prev_reg <= cs_n_s;
    end
  end

  // count only the first 16 rising edges in a frame
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bit_count_reg <= 5'h00;
    end else if (!serial_mode || cs_n_s || cs_fall) begin
      bit_count_reg <= 5'h00;
    end else if (sck_rise && bit_count_reg != acp_pkg::WORD_BITS_COUNT) begin
      bit_count_reg <= bit_count_reg + 5'h01;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      shift_reg <= 16'h0000;
    end else if (serial_mode && !cs_n_s && sck_rise && bit_count_reg != acp_pkg::WORD_BITS_COUNT) begin
      shift_reg <= {shift_reg[14:0], sdi_s};
    end
  end

  // latch flag and register contents after the address byte
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      read_cmd_reg <= 1'b0;
      read_data_reg <= 8'h00;
    end else if (cs_n_s) begin
      read_cmd_reg <= 1'b0;
    end else if (bit_count_reg == acp_pkg::DATA_PHASE_START && !sck_s && sck_prev_reg) begin
      read_cmd_reg <= shift_reg[7];
      read_data_reg <= rif.rd_data;
    end else if (read_cmd_reg && sck_fall) begin
      read_data_reg <= {read_data_reg[6:0], 1'b0};
    end
  end

  // Address bits sit higher once fifteen bits are in, for the write strobe
  assign rif.addr = (bit_count_reg == 5'h0F) ? shift_reg[13:7] : shift_reg[6:0];

  // write on the sixteenth rising edge for a write command
  assign rif.wr_en = serial_mode && !cs_n_s && sck_rise && (bit_count_reg == 5'h0F) && !shift_reg[14];
  assign rif.wr_data = {shift_reg[6:0], sdi_s};

  // drive low for zero read bits in the last eight periods
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sdo_low_reg <= 1'b0;
    end else begin
      sdo_low_reg <= serial_mode && !cs_n_s && read_cmd_reg && !read_data_reg[7]
        && bit_count_reg >= acp_pkg::DATA_PHASE_START && bit_count_reg != acp_pkg::WORD_BITS_COUNT;
    end
  end
  // open drain: only ever drives zero
  assign sdo_pin_out = 1'b0;
  assign sdo_pin_oe_n = !sdo_low_reg;

  acp_reg_bank u_bank (
    .sys_clk(sys_clk),
    .reset(reset),
    .rif(rif.bank),
    .power_down_reg(power_down_reg),
    .timing_reg(timing_reg),
    .driver_mode_reg(driver_mode_reg),
    .data_format_reg(data_format_reg)
  );

  // brief forced sleep after software reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sleep_count_reg <= 4'h0;
    end else if (rif.soft_reset) begin
      sleep_count_reg <= acp_pkg::RESET_SLEEP_CYCLES;
    end else if (sleep_count_reg != 4'h0) begin
      sleep_count_reg <= sleep_count_reg - 4'h1;
    end
  end

  // --------------------------------------------------------------
  // Mode outputs
  // --------------------------------------------------------------
  logic [1:0] format_next;
  logic [2:0] current_next;

  // unused codes fall back to defaults
  always_comb begin
    format_next = driver_mode_reg[acp_pkg::FORMAT_LSB +: 2];
    if (format_next == acp_pkg::FORMAT_UNUSED) begin
      format_next = acp_pkg::FORMAT_FULL_CMOS;
    end
    current_next = driver_mode_reg[acp_pkg::LVDS_CURRENT_LSB +: 3];
    if (current_next == acp_pkg::LVDS_CURRENT_UNUSED) begin
      current_next = acp_pkg::LVDS_CURRENT_3P5MA;
    end
  end

  // static pins or registers steer the modes
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      duty_cycle_stabilizer <= 1'b0;
      power_down_code <= 2'h0;
      output_format_mode <= 2'h0;
      lvds_drive_current <= 3'h0;
      internal_termination <= 1'b0;
      output_tristate <= 1'b0;
      outclk_invert <= 1'b0;
      outclk_phase_delay <= 2'h0;
      test_pattern_select <= 3'h0;
      alt_bit_polarity <= 1'b0;
      output_randomizer <= 1'b0;
      twos_complement <= 1'b0;
    end else if (strap_s) begin
      duty_cycle_stabilizer <= cs_n_s;
      power_down_code <= {sdi_s, sdo_s};
      output_format_mode <= sck_s ? acp_pkg::FORMAT_DDR_LVDS : acp_pkg::FORMAT_FULL_CMOS;
      lvds_drive_current <= acp_pkg::LVDS_CURRENT_3P5MA;
      internal_termination <= 1'b0;
      output_tristate <= 1'b0;
      outclk_invert <= 1'b0;
      outclk_phase_delay <= 2'h0;
      test_pattern_select <= 3'h0;
      alt_bit_polarity <= 1'b0;
      output_randomizer <= 1'b0;
      twos_complement <= 1'b0;
    end else begin
      duty_cycle_stabilizer <= timing_reg[acp_pkg::DCS_BIT];
      outclk_invert <= timing_reg[acp_pkg::OUTCLK_INVERT_BIT];
      outclk_phase_delay <= timing_reg[acp_pkg::OUTCLK_PHASE_LSB +: 2];
      // register code, sleep forced after reset
      power_down_code <= (sleep_count_reg != 4'h0 || rif.soft_reset) ? acp_pkg::POWER_SLEEP
        : power_down_reg[1:0];
      output_format_mode <= format_next;
      lvds_drive_current <= current_next;
      internal_termination <= driver_mode_reg[acp_pkg::TERMINATION_BIT];
      output_tristate <= driver_mode_reg[acp_pkg::TRISTATE_BIT];
      test_pattern_select <= data_format_reg[acp_pkg::TEST_PATTERN_LSB +: 3];
      alt_bit_polarity <= data_format_reg[acp_pkg::ALT_POLARITY_BIT];
      output_randomizer <= data_format_reg[acp_pkg::RANDOMIZER_BIT];
      twos_complement <= data_format_reg[acp_pkg::TWOS_COMP_BIT];
    end
  end

  // effective shift in eighths of a period
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      outclk_shift_eighths <= 3'h0;
    end else begin
      outclk_shift_eighths <= {1'b0, outclk_phase_delay} + {outclk_invert, 2'h0};
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  // chip-select level reaches stabilizer in static mode
  chk_strap_dcs_follow: assert property (@(posedge sys_clk) disable iff (reset)
    !reset && strap_s |=> duty_cycle_stabilizer == $past(cs_n_s))
    else $error("Stabilizer does not follow chip-select in static mode");
  // clock pin high picks DDR LVDS in static mode
  chk_strap_format: assert property (@(posedge sys_clk) disable iff (reset)
    !reset && strap_s && sck_s |=> output_format_mode == 2'h1 && lvds_drive_current == 3'h0 && !internal_termination)
    else $error("Static format wrong");
  chk_strap_power: assert property (@(posedge sys_clk) disable iff (reset)
    !reset && strap_s |=> power_down_code == {$past(sdi_s), $past(sdo_s)})
    else $error("Static power code wrong");
  chk_edge_limit: assert property (@(posedge sys_clk) disable iff (reset)
    bit_count_reg == 5'h10 && sck_rise |=> bit_count_reg == 5'h10 || $past(cs_n_s))
    else $error("Edges beyond sixteen counted");
  chk_reset_sleep: assert property (@(posedge sys_clk) disable iff (reset)
    rif.soft_reset && !strap_s |=> (power_down_code == 2'h3) [*2])
    else $error("Software reset did not force sleep");
  chk_sdo_open_drain: assert property (@(posedge sys_clk) disable iff (reset)
    !sdo_pin_oe_n |-> !sdo_pin_out && serial_mode)
    else $error("Serial-out driven high or outside serial mode");
  chk_read_no_write: assert property (@(posedge sys_clk) disable iff (reset)
    read_cmd_reg |-> !rif.wr_en)
    else $error("Read command caused a write");
  chk_tristate_map: assert property (@(posedge sys_clk) disable iff (reset)
    !strap_s && !$past(strap_s) |-> output_tristate == $past(driver_mode_reg[2]))
    else $error("Tristate does not follow register");

  cov_write_cmd: cover property (@(posedge sys_clk) disable iff (reset) rif.wr_en);
  cov_read_cmd: cover property (@(posedge sys_clk) disable iff (reset) read_cmd_reg && sck_fall);
  cov_soft_reset: cover property (@(posedge sys_clk) disable iff (reset) rif.soft_reset);
  cov_static_mode: cover property (@(posedge sys_clk) disable iff (reset) strap_s && sck_s);
endmodule

// File: dv/acp_host_model.sv
// Host model driving the configuration pins, with a pull-up on serial-out
`timescale 1ns/100ps
module acp_host_model (
  input wire logic sys_clk,
  input wire logic interface_select,
  output logic cs_n_pin,
  output logic sck_pin,
  output logic sdi_pin,
  output logic sdo_pin_in,
  input wire logic sdo_pin_out,
  input wire logic sdo_pin_oe_n
);
  localparam int HALF = 20; // 80 ns half period of the link clock
  logic sdo_static;
  // pull-up resolves the open drain in serial mode
  assign sdo_pin_in = interface_select ? sdo_static : (sdo_pin_oe_n ? 1'b1 : sdo_pin_out);
  // Idle: deselected, clock parked low
  initial begin
    cs_n_pin = 1'b1;
    sck_pin = 1'b0;
    sdi_pin = 1'b0;
    sdo_static = 1'b0;
  end
  // Static levels on all four pins
  task automatic set_pins(input logic cs, input logic sck, input logic sdi, input logic sdo);
    @(posedge sys_clk);
    cs_n_pin <= cs;
    sck_pin <= sck;
    sdi_pin <= sdi;
    sdo_static <= sdo;
  endtask
  // framed word, MSB first, readback taken on rises 9 to 16
  task automatic xfer(input logic rw, input logic [6:0] addr, input logic [7:0] data, input int nclk,
                      output logic [7:0] rdata);
    logic [15:0] word;
    word = {rw, addr, data};
    rdata = 8'h00;
    @(posedge sys_clk);
    cs_n_pin <= 1'b0;
    sdi_pin <= word[15];
    repeat (HALF) @(posedge sys_clk);
    for (int i = 0; i < nclk; i++) begin
      sck_pin <= 1'b1;
      if (i >= 8 && i < 16) rdata = {rdata[6:0], sdo_pin_in};
      repeat (HALF) @(posedge sys_clk);
      sck_pin <= 1'b0;
      sdi_pin <= (i < 15) ? word[14 - i] : 1'b1;
      repeat (HALF) @(posedge sys_clk);
    end
    cs_n_pin <= 1'b1;
    repeat (HALF) @(posedge sys_clk);
  endtask
endmodule

// File: dv/acp_config_port_tb.sv
// Self-checking bench for the mode configuration port
`timescale 1ns/100ps
module acp_config_port_tb;
  logic sys_clk, reset, interface_select, cs_n_pin, sck_pin, sdi_pin, sdo_pin_in, sdo_pin_out, sdo_pin_oe_n;
  logic duty_cycle_stabilizer, internal_termination, output_tristate, outclk_invert;
  logic alt_bit_polarity, output_randomizer, twos_complement;
  logic [1:0] power_down_code, output_format_mode, outclk_phase_delay;
  logic [2:0] lvds_drive_current, outclk_shift_eighths, test_pattern_select;
  int bad_count = 0;
  int total_checks = 0;
  int cycle_count = 0;
  int sleep_count = 0;
  logic [7:0] rm [0:4];
  logic [7:0] rd;
  logic [21:0] obs;
  logic [6:0] tbl_a [0:7] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h02, 7'h03, 7'h03, 7'h01};
  logic [7:0] tbl_d [0:7] = '{8'hFE, 8'hFF, 8'hFF, 8'hFF, 8'h0B, 8'h51, 8'h33, 8'h01};
  // ----------------------------------------
  // Design, host and observation
  // ----------------------------------------
  acp_config_port uut (.sys_clk(sys_clk), .reset(reset), .interface_select(interface_select),
    .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .sdi_pin(sdi_pin), .sdo_pin_in(sdo_pin_in),
    .sdo_pin_out(sdo_pin_out), .sdo_pin_oe_n(sdo_pin_oe_n), .duty_cycle_stabilizer(duty_cycle_stabilizer),
    .power_down_code(power_down_code), .output_format_mode(output_format_mode),
    .lvds_drive_current(lvds_drive_current), .internal_termination(internal_termination),
    .output_tristate(output_tristate), .outclk_invert(outclk_invert), .outclk_phase_delay(outclk_phase_delay),
    .outclk_shift_eighths(outclk_shift_eighths), .test_pattern_select(test_pattern_select),
    .alt_bit_polarity(alt_bit_polarity), .output_randomizer(output_randomizer), .twos_complement(twos_complement));
  acp_host_model host (.sys_clk(sys_clk), .interface_select(interface_select), .cs_n_pin(cs_n_pin),
    .sck_pin(sck_pin), .sdi_pin(sdi_pin), .sdo_pin_in(sdo_pin_in), .sdo_pin_out(sdo_pin_out),
    .sdo_pin_oe_n(sdo_pin_oe_n));
  assign obs = {duty_cycle_stabilizer, power_down_code, output_format_mode, lvds_drive_current,
    internal_termination, output_tristate, outclk_invert, outclk_phase_delay, outclk_shift_eighths,
    test_pattern_select, alt_bit_polarity, output_randomizer, twos_complement};
  // Clock, cycle limit and sleep counter
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycle_count++;
    if (power_down_code === acp_pkg::POWER_SLEEP) sleep_count++;
    if (cycle_count == 40000) begin
      bad_count++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // Checking tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [21:0] exp, input logic [21:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  function automatic logic [21:0] expect_out();
    logic [1:0] fmt;
    logic [2:0] cur;
    fmt = (rm[3][1:0] == acp_pkg::FORMAT_UNUSED) ? acp_pkg::FORMAT_FULL_CMOS : rm[3][1:0];
    cur = (rm[3][6:4] == acp_pkg::LVDS_CURRENT_UNUSED) ? acp_pkg::LVDS_CURRENT_3P5MA : rm[3][6:4];
    return {rm[2][0], rm[1][1:0], fmt, cur, rm[3][3], rm[3][2], rm[2][3], rm[2][2:1], rm[2][3:1],
      rm[4][5:3], rm[4][2:0]};
  endfunction
  // write, then compare every mode output
  task automatic wr(input logic [6:0] addr, input logic [7:0] data, input int nclk);
    logic [7:0] mask [0:4];
    mask = '{8'h00, acp_pkg::POWER_DOWN_MASK, acp_pkg::TIMING_MASK, acp_pkg::DRIVER_MODE_MASK,
      acp_pkg::DATA_FORMAT_MASK};
    host.xfer(1'b0, addr, data, nclk, rd);
    if (addr == 7'h00 && data[7]) rm = '{default: 8'h00};
    else if (addr <= 7'h04) rm[addr[2:0]] = data & mask[addr[2:0]];
    repeat (12) @(posedge sys_clk);
    check("mode outputs after write", expect_out(), obs);
  endtask
  task automatic rdback(input logic [6:0] addr, input logic [7:0] exp);
    host.xfer(1'b1, addr, 8'hA5, 16, rd);
    repeat (12) @(posedge sys_clk);
    check("readback", 22'(exp), 22'(rd));
    check("mode outputs after read", expect_out(), obs);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    interface_select = 1'b1;
    rm = '{default: 8'h00};
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      host.set_pins(i[3], i[2], i[1], i[0]);
      repeat (8) @(posedge sys_clk);
      check("static pins", 22'({i[3], i[1:0], i[2] ? acp_pkg::FORMAT_DDR_LVDS : acp_pkg::FORMAT_FULL_CMOS,
        acp_pkg::LVDS_CURRENT_3P5MA, 1'b0}), 22'(obs[21:13]));
      check("static serial-out released", 22'(1), 22'(sdo_pin_oe_n));
    end
    $display("test static_pins done");
    host.set_pins(1'b1, 1'b0, 1'b0, 1'b0);
    interface_select <= 1'b0;
    repeat (8) @(posedge sys_clk);
    wr(7'h00, 8'h80, 16);
    for (int k = 0; k < 8; k++) begin
      wr(tbl_a[k], tbl_d[k], 16);
      rdback(tbl_a[k], rm[tbl_a[k][2:0]]);
    end
    $display("test write_readback done");
    wr(7'h02, 8'h05, 18);
    rdback(7'h02, 8'h05);
    wr(7'h10, 8'hFF, 16);
    rdback(7'h10, 8'h00);
    $display("test extra_edges_unmapped done");
    sleep_count = 0;
    wr(7'h00, 8'h80, 16);
    check("forced sleep length", 22'(1), 22'(sleep_count >= 8));
    for (int a = 1; a < 5; a++) rdback(7'(a), 8'h00);
    $display("test soft_reset done");
    print_verdict();
  end
endmodule
